// ### pkg/vdc_pkg.sv
// Shared constants for the video decoder front control registers.
// Assumes a single clock domain and a sub-address register port
// driven by the serial control interface logic of the decoder.
package vdc_pkg;

   // Sub addresses of the four control registers.
   localparam logic [7:0] VDC_SUB_INPUT_CTRL  = 8'h00;
   localparam logic [7:0] VDC_SUB_BRIGHTNESS  = 8'h01;
   localparam logic [7:0] VDC_SUB_CONTRAST    = 8'h02;
   localparam logic [7:0] VDC_SUB_PHASE       = 8'h03;

   // Reset values.
   localparam logic [7:0] VDC_RST_INPUT_CTRL  = 8'hf8;
   localparam logic [7:0] VDC_RST_BRIGHTNESS  = 8'h80;
   localparam logic [7:0] VDC_RST_CONTRAST    = 8'hbd;
   localparam logic [7:0] VDC_RST_PHASE       = 8'h00;

   // Field positions of the input control register.
   localparam int         VDC_VIC_STD_HI      = 7;
   localparam int         VDC_VIC_STD_LO      = 6;
   localparam int         VDC_VIC_TRAP_DIS    = 5;
   localparam int         VDC_VIC_LPF_DIS     = 4;
   localparam int         VDC_VIC_AGC_EN      = 3;
   localparam int         VDC_VIC_MUX_HI      = 2;
   localparam int         VDC_VIC_MUX_LO      = 1;
   localparam int         VDC_VIC_UNUSED      = 0;
   localparam logic [7:0] VDC_VIC_WR_MASK     = 8'hfe;

   // Field positions of the brightness register.
   localparam int         VDC_BRI_SETUP       = 7;
   localparam int         VDC_BRI_SIGN        = 6;

   // Video standard codes.
   localparam logic [1:0] VDC_STD_PAL_BGHIN   = 2'h0;
   localparam logic [1:0] VDC_STD_PAL_M       = 2'h1;
   localparam logic [1:0] VDC_STD_PAL_CN      = 2'h2;
   localparam logic [1:0] VDC_STD_NTSC_M      = 2'h3;

   // Converter multiplexer codes, field value bit2:bit1.
   localparam logic [1:0] VDC_MUX_CVBS0       = 2'h0;
   localparam logic [1:0] VDC_MUX_CVBS1       = 2'h2;
   localparam logic [1:0] VDC_MUX_CVBS2       = 2'h1;
   localparam logic [1:0] VDC_MUX_SVIDEO      = 2'h3;

   // One-hot composite input selects.
   localparam logic [2:0] VDC_SEL_IN0         = 3'h1;
   localparam logic [2:0] VDC_SEL_IN1         = 3'h2;
   localparam logic [2:0] VDC_SEL_IN2         = 3'h4;

   // Luminance arithmetic.
   localparam logic [8:0] VDC_SETUP_HI        = 9'h049;
   localparam logic [8:0] VDC_SETUP_LO        = 9'h040;
   localparam int         VDC_CONTRAST_FRAC   = 7;
   localparam logic [7:0] VDC_LUMA_MAX        = 8'hff;

   // Chroma gain and burst target.
   localparam logic [7:0] VDC_UNITY_GAIN      = 8'h80;
   localparam logic [7:0] VDC_BURST_IRE       = 8'h14;

   // Phase adjust: span and step give the clamp limit in counts.
   localparam int         VDC_HUE_SPAN_DEG    = 30;
   localparam int         VDC_HUE_STEP_MDEG   = 250;
   localparam logic signed [7:0] VDC_HUE_LIMIT =
      8'((VDC_HUE_SPAN_DEG * 1000 / 2) / VDC_HUE_STEP_MDEG);

endpackage : vdc_pkg

// ### verilog/vdc_luma_adjust.sv
// Luminance setup removal, brightness offset, contrast scale, saturation.
// Assumes luma arrives on i_clock from same-clock logic; two-cycle latency.
`timescale 1ns/1ps
module vdc_luma_adjust (
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   input  wire logic       i_clk_en,
   input  wire logic [7:0] i_luma,
   input  wire logic       i_setup_73,
   input  wire logic [6:0] i_brightness,
   input  wire logic [7:0] i_contrast,
   output logic      [7:0] o_luma
);
   import vdc_pkg::*;

   typedef struct packed {
      logic signed [9:0] sum;
      logic        [7:0] luma;
   } vdc_luma_state_t;

   localparam vdc_luma_state_t VDC_LUMA_RST = '{sum: 10'sh000, luma: 8'h00};

   vdc_luma_state_t st_r;
   vdc_luma_state_t st_nxt;

   always_comb begin
      logic [16:0] prod;
      logic [9:0]  scaled;
      prod   = '0;
      scaled = '0;
      st_nxt = st_r;
      // Brightness is added after the setup level is stripped.
      st_nxt.sum = $signed({2'h0, i_luma})
                 - $signed({1'h0, i_setup_73 ? VDC_SETUP_HI : VDC_SETUP_LO})
                 + $signed({{3{i_brightness[VDC_BRI_SIGN]}}, i_brightness});
      // Negative sums clamp to black instead of wrapping.
      if (st_r.sum < 0) begin
         st_nxt.luma = 8'h00;
      end else begin
         prod   = st_r.sum[8:0] * i_contrast;
         scaled = prod[16:VDC_CONTRAST_FRAC];
         st_nxt.luma = (scaled > {2'h0, VDC_LUMA_MAX}) ? VDC_LUMA_MAX : scaled[7:0];
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_r <= VDC_LUMA_RST;
      end else if (i_clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign o_luma = st_r.luma;

   a_contrast_zero_black: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_clk_en && i_contrast == 8'h00) ##1 (i_clk_en && i_contrast == 8'h00)
      |=> o_luma == 8'h00)
      else $error("Zero contrast did not give black luma.");

   a_luma_clip_white: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_clk_en && i_luma == 8'hff && !i_setup_73 && i_brightness == 7'h3f)
      ##1 (i_clk_en && i_contrast == 8'hff) |=> o_luma == VDC_LUMA_MAX)
      else $error("Bright luma wrapped instead of saturating.");

   a_setup_unity_path: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_clk_en && i_luma == 8'h64 && i_setup_73 && i_brightness == 7'h00)
      ##1 (i_clk_en && i_contrast == VDC_UNITY_GAIN) |=> o_luma == 8'h1b)
      else $error("Setup offset of 73 not removed from luma.");

   // A full-scale factor pushes any stripped sum above half scale past white.
   c_luma_clipped: cover property (@(posedge i_clock) disable iff (i_rst)
      i_clk_en && st_r.sum > 10'sh080 && i_contrast == 8'hff);

endmodule : vdc_luma_adjust

// ### verilog/vdc_input_regs.sv
// Video input and picture adjust control registers of the decoder.
// Assumes the serial control logic presents one-cycle sub-address
// write and read strobes on i_clock; the luma and AGC gain inputs
// come from same-clock datapath logic.
//
// Summary of operation
// - Input control bits 7:6 pick standard; 00 is PAL BGHIN, 4.43 MHz, 625 lines.
// - Standard code 01 is PAL M, 3.58 MHz, 60 frames, 525 lines.
// - Code 10 is combination PAL N; code 11 NTSC M and the reset default.
// - Bit 5 low enables luma subcarrier trap; high bypasses it; resets high.
// - Bit 4 low enables chroma low-pass filter; high bypasses it; resets high.
// - Bit 3 high lets chroma AGC drive burst to 20 IRE; default on.
// - Bit 3 low fixes chroma gain at exactly unity.
// - Bits 2:1 select composite input 0, 1 or 2 with codes 00, 10, 01.
// - Code 11 is S-video: luma from input 2, chroma from separate input.
// - Input control bit 0 ignores writes and always reads zero.
// - Brightness bit 7 picks setup removal of 73 when high, 64 when low.
// - Brightness bits 6:0 are a signed offset added to luma, reset zero.
// - Contrast is an unsigned 1.7 fraction multiplying luma after brightness.
// - Contrast resets to 0xbd, a factor near 1.4766.
// - Hue is a signed byte applied as chroma phase offset, reset zero.
// - Each hue count is 0.25 degree; total adjustment span is 30 degrees.
`timescale 1ns/1ps
module vdc_input_regs (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_clk_en,
   // Sub-address register port from the serial control logic.
   input  wire logic [7:0]  i_sub_addr,
   input  wire logic        i_wr_en,
   input  wire logic [7:0]  i_wr_data,
   input  wire logic        i_rd_en,
   output logic      [7:0]  o_rd_data,
   output logic             o_rd_valid,
   // Standard selection.
   output logic      [1:0]  o_std_sel,
   output logic             o_subcarrier_443,
   output logic             o_lines_625,
   output logic             o_fps_50,
   // Filters.
   output logic             o_luma_trap_en,
   output logic             o_chroma_lpf_en,
   // Chroma gain.
   input  wire logic [7:0]  i_agc_gain,
   output logic             o_chroma_agc_en,
   output logic      [7:0]  o_burst_target_ire,
   output logic      [7:0]  o_chroma_gain,
   // Converter multiplexer.
   output logic      [2:0]  o_composite_input_sel,
   output logic             o_svideo_mode,
   output logic             o_separate_chroma_input_en,
   // Chroma phase offset, 0.25 degree per count.
   output logic signed [7:0] o_hue_phase,
   // Luminance path.
   input  wire logic [7:0]  i_luma,
   output logic      [7:0]  o_luma
);
   import vdc_pkg::*;

   typedef struct packed {
      logic        [7:0] vic;
      logic        [7:0] bri;
      logic        [7:0] con;
      logic        [7:0] hue;
      logic signed [7:0] hue_phase;
      logic        [7:0] gain;
      logic        [7:0] rd_data;
      logic              rd_valid;
   } vdc_state_t;

   localparam vdc_state_t VDC_STATE_RST = '{
      vic:       VDC_RST_INPUT_CTRL,
      bri:       VDC_RST_BRIGHTNESS,
      con:       VDC_RST_CONTRAST,
      hue:       VDC_RST_PHASE,
      hue_phase: 8'sh00,
      gain:      VDC_UNITY_GAIN,
      rd_data:   8'h00,
      rd_valid:  1'b0
   };

   vdc_state_t st_r;
   vdc_state_t st_nxt;
   logic [1:0] mux_code;

   // Read decode; an unmapped sub address answers zero.
   function automatic logic [7:0] vdc_read_word(input logic [7:0] addr,
                                                input vdc_state_t st);
      logic [7:0] word;
      word = 8'h00;
      case (addr)
         VDC_SUB_INPUT_CTRL: word = st.vic & VDC_VIC_WR_MASK;
         VDC_SUB_BRIGHTNESS: word = st.bri;
         VDC_SUB_CONTRAST:   word = st.con;
         VDC_SUB_PHASE:      word = st.hue;
         default:            word = 8'h00;
      endcase
      return word;
   endfunction : vdc_read_word

   // The register holds the full signed byte so software reads back what
   // it wrote, but the datapath only gets the documented 30 degree span.
   function automatic logic signed [7:0] vdc_hue_clamp(input logic [7:0] raw);
      logic signed [7:0] val;
      val = $signed(raw);
      if (val > VDC_HUE_LIMIT) begin
         val = VDC_HUE_LIMIT;
      end else if (val < -VDC_HUE_LIMIT) begin
         val = -VDC_HUE_LIMIT;
      end
      return val;
   endfunction : vdc_hue_clamp

   always_comb begin
      st_nxt          = st_r;
      st_nxt.rd_valid = 1'b0;
      if (i_wr_en) begin
         case (i_sub_addr)
            VDC_SUB_INPUT_CTRL: st_nxt.vic = i_wr_data & VDC_VIC_WR_MASK;
            VDC_SUB_BRIGHTNESS: st_nxt.bri = i_wr_data;
            VDC_SUB_CONTRAST:   st_nxt.con = i_wr_data;
            VDC_SUB_PHASE:      st_nxt.hue = i_wr_data;
            default:            st_nxt.vic = st_r.vic;
         endcase
      end
      // A read in the same cycle as a write returns the old contents.
      if (i_rd_en) begin
         st_nxt.rd_valid = 1'b1;
         st_nxt.rd_data  = vdc_read_word(i_sub_addr, st_r);
      end
      st_nxt.hue_phase = vdc_hue_clamp(st_r.hue);
      // The AGC loop only steers gain when enabled; otherwise unity.
      st_nxt.gain = st_r.vic[VDC_VIC_AGC_EN] ? i_agc_gain : VDC_UNITY_GAIN;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_r <= VDC_STATE_RST;
      end else if (i_clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign o_rd_data  = st_r.rd_data;
   assign o_rd_valid = st_r.rd_valid;

   // Standard decode.
   assign o_std_sel        = st_r.vic[VDC_VIC_STD_HI:VDC_VIC_STD_LO];
   assign o_subcarrier_443 = (o_std_sel == VDC_STD_PAL_BGHIN);
   assign o_lines_625      = (o_std_sel == VDC_STD_PAL_BGHIN) || (o_std_sel == VDC_STD_PAL_CN);
   assign o_fps_50         = o_lines_625;

   // Filter controls are stored as disables.
   assign o_luma_trap_en  = ~st_r.vic[VDC_VIC_TRAP_DIS];
   assign o_chroma_lpf_en = ~st_r.vic[VDC_VIC_LPF_DIS];

   assign o_chroma_agc_en    = st_r.vic[VDC_VIC_AGC_EN];
   assign o_burst_target_ire = VDC_BURST_IRE;
   assign o_chroma_gain      = st_r.gain;

   // Converter multiplexer steering.
   assign mux_code = st_r.vic[VDC_VIC_MUX_HI:VDC_VIC_MUX_LO];

   always_comb begin
      o_composite_input_sel      = VDC_SEL_IN0;
      o_svideo_mode              = 1'b0;
      o_separate_chroma_input_en = 1'b0;
      case (mux_code)
         VDC_MUX_CVBS0: o_composite_input_sel = VDC_SEL_IN0;
         VDC_MUX_CVBS1: o_composite_input_sel = VDC_SEL_IN1;
         VDC_MUX_CVBS2: o_composite_input_sel = VDC_SEL_IN2;
         VDC_MUX_SVIDEO: begin
            o_composite_input_sel      = VDC_SEL_IN2;
            o_svideo_mode              = 1'b1;
            o_separate_chroma_input_en = 1'b1;
         end
         default: o_composite_input_sel = VDC_SEL_IN0;
      endcase
   end

   assign o_hue_phase = st_r.hue_phase;

   vdc_luma_adjust u_luma (
      .i_clock      (i_clock),
      .i_rst        (i_rst),
      .i_clk_en     (i_clk_en),
      .i_luma       (i_luma),
      .i_setup_73   (st_r.bri[VDC_BRI_SETUP]),
      .i_brightness (st_r.bri[VDC_BRI_SIGN:0]),
      .i_contrast   (st_r.con),
      .o_luma       (o_luma)
   );

   // Checks.
   a_std_write_takes: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_clk_en && i_wr_en && i_sub_addr == VDC_SUB_INPUT_CTRL)
      |=> o_std_sel == $past(i_wr_data[VDC_VIC_STD_HI:VDC_VIC_STD_LO]))
      else $error("Standard field did not follow the write.");

   a_std_pal_m_525: assert property (@(posedge i_clock) disable iff (i_rst)
      o_std_sel == VDC_STD_PAL_M |-> !o_subcarrier_443 && !o_lines_625 && !o_fps_50)
      else $error("PAL M decoded with wrong carrier or line count.");

   a_std_625_codes: assert property (@(posedge i_clock) disable iff (i_rst)
      o_lines_625 |-> (o_std_sel == VDC_STD_PAL_BGHIN || o_std_sel == VDC_STD_PAL_CN))
      else $error("625 line mode flagged for a 525 line standard.");

   a_trap_write: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_clk_en && i_wr_en && i_sub_addr == VDC_SUB_INPUT_CTRL)
      |=> o_luma_trap_en == !$past(i_wr_data[VDC_VIC_TRAP_DIS]))
      else $error("Trap filter enable does not match written bit.");

   a_lpf_write: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_clk_en && i_wr_en && i_sub_addr == VDC_SUB_INPUT_CTRL)
      |=> o_chroma_lpf_en == !$past(i_wr_data[VDC_VIC_LPF_DIS]))
      else $error("Chroma low-pass enable does not match written bit.");

   a_agc_gain_pass: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_clk_en && o_chroma_agc_en) |=> o_chroma_gain == $past(i_agc_gain))
      else $error("Chroma gain did not follow the AGC loop.");

   a_agc_off_unity: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_clk_en && !o_chroma_agc_en) |=> o_chroma_gain == VDC_UNITY_GAIN)
      else $error("Chroma gain not unity with AGC off.");

   a_mux_composite: assert property (@(posedge i_clock) disable iff (i_rst)
      !o_svideo_mode |-> $onehot(o_composite_input_sel) && !o_separate_chroma_input_en)
      else $error("Composite mode selects more than one input.");

   a_mux_svideo: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_clk_en && i_wr_en && i_sub_addr == VDC_SUB_INPUT_CTRL
       && i_wr_data[VDC_VIC_MUX_HI:VDC_VIC_MUX_LO] == VDC_MUX_SVIDEO)
      |=> o_svideo_mode && o_separate_chroma_input_en
          && o_composite_input_sel == VDC_SEL_IN2)
      else $error("S-video code did not route luma from input 2.");

   a_unused_bit_zero: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_clk_en && i_rd_en && i_sub_addr == VDC_SUB_INPUT_CTRL)
      |=> o_rd_valid && o_rd_data[VDC_VIC_UNUSED] == 1'b0)
      else $error("Unused input control bit read back as one.");

   a_contrast_readback: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_clk_en && i_wr_en && i_sub_addr == VDC_SUB_CONTRAST)
      ##1 (i_clk_en && !i_wr_en)
      ##1 (i_clk_en && i_rd_en && !i_wr_en && i_sub_addr == VDC_SUB_CONTRAST)
      |=> o_rd_data == $past(i_wr_data, 3))
      else $error("Contrast register did not hold its written value.");

   a_hue_in_span: assert property (@(posedge i_clock) disable iff (i_rst)
      o_hue_phase <= VDC_HUE_LIMIT && o_hue_phase >= -VDC_HUE_LIMIT)
      else $error("Hue phase offset outside its span.");

   a_hue_follows: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_clk_en && $signed(st_r.hue) <= VDC_HUE_LIMIT && $signed(st_r.hue) >= -VDC_HUE_LIMIT)
      |=> o_hue_phase == $signed($past(st_r.hue)))
      else $error("In-range hue value not applied as phase offset.");

   c_pal_with_filters: cover property (@(posedge i_clock) disable iff (i_rst)
      o_std_sel == VDC_STD_PAL_BGHIN && o_luma_trap_en && o_chroma_lpf_en);

   c_svideo_entered: cover property (@(posedge i_clock) disable iff (i_rst)
      !o_svideo_mode ##1 o_svideo_mode);

   c_hue_clamped: cover property (@(posedge i_clock) disable iff (i_rst)
      $signed(st_r.hue) > VDC_HUE_LIMIT);

   c_read_back: cover property (@(posedge i_clock) disable iff (i_rst)
      o_rd_valid && o_rd_data != 8'h00);

endmodule : vdc_input_regs

// ### testbench/vdc_host_model.sv
// Host controller model driving the decoder's sub-address register port.
// Assumes one caller at a time and a bench that owns the clock enable.
`timescale 1ns/1ps
module vdc_host_model (
   input  wire logic       i_clock,
   input  wire logic [7:0] i_rd_data,
   input  wire logic       i_rd_valid,
   output logic      [7:0] o_sub_addr,
   output logic            o_wr_en,
   output logic      [7:0] o_wr_data,
   output logic            o_rd_en
);
   initial begin
      o_sub_addr = 8'h00;
      o_wr_en    = 1'b0;
      o_wr_data  = 8'h00;
      o_rd_en    = 1'b0;
   end

   // Everything moves on the falling edge, so the taking rising edge sees it settled.
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge i_clock);
      o_sub_addr = addr;
      o_wr_data  = data;
      o_wr_en    = 1'b1;
      @(negedge i_clock);
      o_wr_en    = 1'b0;
      // Released data is inverted so a late sample cannot match by luck.
      o_wr_data  = ~data;
   endtask : write_reg

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      int n;
      @(negedge i_clock);
      o_sub_addr = addr;
      o_rd_en    = 1'b1;
      @(negedge i_clock);
      o_rd_en    = 1'b0;
      n          = 0;
      while (i_rd_valid !== 1'b1 && n < 4) begin
         @(negedge i_clock);
         n++;
      end
      data = i_rd_data;
      ok   = (n < 4);
   endtask : read_reg

   // A PAL setup always turns both filters on by clearing their bypass bits.
   task automatic select_pal(input logic [1:0] std, input logic agc, input logic [1:0] mux);
      write_reg(8'h00, {std, 2'b00, agc, mux, 1'b0});
   endtask : select_pal
endmodule : vdc_host_model

// ### testbench/vdc_input_regs_bench.sv
// Self-checking bench for the video input and picture adjust registers.
// Assumes the host model in the same folder and the shared vdc_pkg.
`timescale 1ns/1ps
`define VDC_CHK(g_val, e_val) \
   begin \
      samples_checked++; \
      if ((g_val) !== (e_val)) begin \
         mismatches++; \
         $display("FAIL %0t got %h expected %h", $time, g_val, e_val); \
      end \
   end
module vdc_input_regs_bench;
   import vdc_pkg::*;
   logic              i_clock = 1'b0;
   logic              i_rst = 1'b1;
   logic              i_clk_en = 1'b1;
   logic        [7:0] i_sub_addr, i_wr_data, o_rd_data, o_chroma_gain, o_burst_target_ire;
   logic              i_wr_en, i_rd_en, o_rd_valid, o_subcarrier_443, o_lines_625, o_fps_50;
   logic        [1:0] o_std_sel;
   logic              o_luma_trap_en, o_chroma_lpf_en, o_chroma_agc_en;
   logic              o_svideo_mode, o_separate_chroma_input_en;
   logic        [2:0] o_composite_input_sel;
   logic signed [7:0] o_hue_phase;
   logic        [7:0] i_agc_gain = 8'h55;
   logic        [7:0] i_luma = 8'h00;
   logic        [7:0] o_luma;
   logic        [7:0] y_exp;
   int                mismatches = 0;
   int                samples_checked = 0;
   logic        [2:0] sel_tab [4] = '{3'h1, 3'h4, 3'h2, 3'h4};
   logic        [7:0] hue_in [7] = '{8'h05, 8'h3c, 8'h3d, 8'h7f, 8'hc4, 8'h80, 8'hff};
   logic        [7:0] hue_exp [7] = '{8'h05, 8'h3c, 8'h3c, 8'h3c, 8'hc4, 8'hc4, 8'hff};
   logic        [7:0] bri_tab [6] = '{8'h80, 8'h80, 8'h3f, 8'h40, 8'h7f, 8'h00};
   logic        [7:0] con_tab [6] = '{8'hbd, 8'h80, 8'hff, 8'h80, 8'h40, 8'h00};
   logic        [7:0] y_tab [6] = '{8'd200, 8'd100, 8'd255, 8'd100, 8'd150, 8'd200};

   always #10 i_clock = ~i_clock;

   vdc_input_regs i_dut (.i_clock, .i_rst, .i_clk_en, .i_sub_addr, .i_wr_en, .i_wr_data,
      .i_rd_en, .o_rd_data, .o_rd_valid, .o_std_sel, .o_subcarrier_443, .o_lines_625,
      .o_fps_50, .o_luma_trap_en, .o_chroma_lpf_en, .i_agc_gain, .o_chroma_agc_en,
      .o_burst_target_ire, .o_chroma_gain, .o_composite_input_sel, .o_svideo_mode,
      .o_separate_chroma_input_en, .o_hue_phase, .i_luma, .o_luma);

   vdc_host_model i_host (.i_clock, .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid),
      .o_sub_addr(i_sub_addr), .o_wr_en(i_wr_en), .o_wr_data(i_wr_data), .o_rd_en(i_rd_en));

   task automatic report_and_stop;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] data;
      logic       ok;
      i_host.read_reg(addr, data, ok);
      if (!ok) begin
         mismatches++;
         $display("FAIL %0t read answer never came", $time);
         report_and_stop();
      end
      `VDC_CHK(data, exp)
   endtask : rd_chk

   // Reference luma: setup removal, signed offset, 1.7 scale, clamp at both ends.
   function automatic logic [7:0] luma_exp(input logic [7:0] y, input logic [7:0] b,
                                           input logic [7:0] c);
      int s;
      s = int'(y) - (b[7] ? 73 : 64) + int'($signed(b[6:0]));
      if (s < 0) begin
         return 8'h00;
      end
      s = (s * int'(c)) >>> 7;
      return (s > 255) ? 8'hff : 8'(s);
   endfunction : luma_exp

   initial begin
      repeat (12) @(posedge i_clock);
      @(negedge i_clock);
      i_rst = 1'b0;
      `VDC_CHK(o_std_sel, 2'b11)
      `VDC_CHK(o_luma_trap_en, 1'b0)
      `VDC_CHK(o_chroma_lpf_en, 1'b0)
      `VDC_CHK(o_chroma_agc_en, 1'b1)
      `VDC_CHK(o_composite_input_sel, 3'h1)
      `VDC_CHK(o_hue_phase, 8'h00)
      rd_chk(8'h00, 8'hf8);
      rd_chk(8'h01, 8'h80);
      rd_chk(8'h02, 8'hbd);
      rd_chk(8'h03, 8'h00);
      for (int s = 0; s < 4; s++) begin
         i_host.select_pal(s[1:0], 1'b0, 2'b00);
         `VDC_CHK(o_std_sel, s[1:0])
         `VDC_CHK(o_subcarrier_443, 1'(s == 0))
         `VDC_CHK(o_lines_625, 1'(s == 0 || s == 2))
         `VDC_CHK(o_fps_50, 1'(s == 0 || s == 2))
         `VDC_CHK(o_luma_trap_en, 1'b1)
         `VDC_CHK(o_chroma_lpf_en, 1'b1)
         `VDC_CHK(o_chroma_agc_en, 1'b0)
      end
      @(negedge i_clock);
      `VDC_CHK(o_chroma_gain, 8'h80)
      for (int m = 0; m < 4; m++) begin
         i_host.write_reg(8'h00, {5'h1f, m[1:0], 1'b1});
         `VDC_CHK(o_composite_input_sel, sel_tab[m])
         `VDC_CHK(o_svideo_mode, 1'(m == 3))
         `VDC_CHK(o_separate_chroma_input_en, 1'(m == 3))
         `VDC_CHK(o_luma_trap_en, 1'b0)
         rd_chk(8'h00, {5'h1f, m[1:0], 1'b0});
      end
      i_agc_gain = 8'h37;
      @(negedge i_clock);
      `VDC_CHK(o_chroma_gain, 8'h37)
      `VDC_CHK(o_burst_target_ire, 8'h14)
      for (int h = 0; h < 7; h++) begin
         i_host.write_reg(8'h03, hue_in[h]);
         @(negedge i_clock);
         `VDC_CHK(o_hue_phase, hue_exp[h])
         rd_chk(8'h03, hue_in[h]);
      end
      for (int k = 0; k < 6; k++) begin
         i_host.write_reg(8'h01, bri_tab[k]);
         i_host.write_reg(8'h02, con_tab[k]);
         i_luma = y_tab[k];
         repeat (2) @(negedge i_clock);
         y_exp = luma_exp(y_tab[k], bri_tab[k], con_tab[k]);
         `VDC_CHK(o_luma, y_exp)
         rd_chk(8'h01, bri_tab[k]);
      end
      rd_chk(8'h02, 8'h00);
      i_host.write_reg(8'h02, VDC_RST_CONTRAST);
      rd_chk(8'h02, 8'hbd);
      i_host.write_reg(8'h04, 8'h55);
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h03, 8'hff);
      i_clk_en = 1'b0;
      i_host.write_reg(8'h03, 8'h11);
      i_clk_en = 1'b1;
      rd_chk(8'h03, 8'hff);
      report_and_stop();
   end
endmodule : vdc_input_regs_bench
